// File: amtc_pkg.sv
// Shared types and constants for the measurement ADC control and temperature conversion block.
// Assumes a single system clock; all users reference items as amtc_pkg::name.
package amtc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int RAW_W  = 10;
    localparam int RES_W  = 13;
    localparam int HI_W   = 8;
    localparam int LO_W   = 5;
    localparam int TMP_W  = 11;
    localparam int THI_W  = 8;
    localparam int TLO_W  = 3;
    localparam int TRAW_W = 13;
    localparam int GAIN_W = 11;
    localparam int OFS_W  = 9;
    localparam int NTCH   = 3;
    localparam int NCUR   = 2;
    localparam int SCH_W  = 16;

    // ------------------------------------------------------------
    // Scaling and reset values
    // ------------------------------------------------------------
    localparam int GAIN_FRAC                = 10;
    localparam int AVG_FRAC                 = 3;
    localparam int COEF8_SH                 = 3;
    localparam int COEF16_SH                = 4;
    localparam logic [13:0] KELVIN_Q        = 14'h0445;
    localparam logic [TMP_W-1:0] FAULT_POS  = 11'h3FF;
    localparam logic [TMP_W-1:0] FAULT_NEG  = 11'h401;
    localparam logic [RES_W-1:0] RES_RST    = 13'h0000;
    localparam logic [TMP_W-1:0] TMP_RST    = 11'h000;
    localparam logic [SCH_W-1:0] SCH_RST    = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SRC_HVCUR, SRC_CUR1, SRC_HVOLT, SRC_VOLT} amtc_src_t;
    typedef enum logic [1:0] {DIV1, DIV3, DIV4, DIV8} amtc_div_t;
    typedef enum logic [1:0] {OWN_HOST, OWN_TRIM, OWN_SCH0, OWN_SCH1} amtc_own_t;
    typedef enum logic [1:0] {COEF1, COEF8, COEF16} amtc_coef_t;

    typedef struct packed {
        amtc_src_t src;
        logic      hi_range;
    } amtc_req_t;

    typedef struct packed {
        logic [1:0]        ch;
        logic              short_det;
        logic              open_det;
        logic [TRAW_W-1:0] raw;
    } amtc_tsamp_t;

endpackage

// File: amtc_top.sv
// Measurement ADC control (arbitration, scaling, current averaging) and temperature conversion.
// Assumes the ADC, temperature ADC, trim circuit and I2C engine are logic on SYS_CLK.
//
// Function
// - Selector picks one of four ADC sources
// - Voltage monitor divides by three or one
// - High-voltage monitor always divides by eight or four
// - Drive selector; accept host and trim requests
// - Periodic current conversions, eight-sample weighted average
// - Voltage results scaled to 2 mV per LSB
// - Current results stored without multiplication
// - Host request routes channel, latches result
// - Result widened to 13 bits
// - Result split into 8 high, 5 low bits
// - Three temperature channels, dedicated converter
// - Temperature is 11-bit two's complement, quarter degree
// - Ideality correction scales absolute temperature
// - Signed per-channel offset added
// - Short/open gives fixed reading by fault bit
// - Temperature filtered, held in two fields
// - Exponential filter coefficient 1, 8 or 16
`timescale 1ns/1ns
module amtc_top
(
    input  wire logic                                    SYS_CLK,
    input  wire logic                                    RSTN,
    input  wire logic                                    HOST_REQ,
    input  wire amtc_pkg::amtc_req_t                     HOST_SEL,
    output logic                                         HOST_DONE,
    output logic [amtc_pkg::HI_W-1:0]                    RESULT_HI,
    output logic [amtc_pkg::LO_W-1:0]                    RESULT_LO,
    input  wire logic                                    TRIM_REQ,
    input  wire amtc_pkg::amtc_req_t                     TRIM_SEL,
    output logic                                         TRIM_DONE,
    output logic [amtc_pkg::RES_W-1:0]                   TRIM_RESULT,
    input  wire logic [amtc_pkg::SCH_W-1:0]              SCHED_PERIOD,
    output logic [amtc_pkg::NCUR-1:0][amtc_pkg::RES_W-1:0] CUR_AVG,
    output amtc_pkg::amtc_src_t                          ADC_SEL,
    output amtc_pkg::amtc_div_t                          ADC_DIV,
    output logic                                         ADC_START,
    input  wire logic                                    ADC_DONE,
    input  wire logic [amtc_pkg::RAW_W-1:0]              ADC_DATA,
    input  wire logic                                    TEMP_VALID,
    input  wire amtc_pkg::amtc_tsamp_t                   TEMP_IN,
    input  wire logic [amtc_pkg::NTCH-1:0][amtc_pkg::GAIN_W-1:0] TEMP_GAIN,
    input  wire logic [amtc_pkg::NTCH-1:0][amtc_pkg::OFS_W-1:0]  TEMP_OFS,
    input  wire logic [amtc_pkg::NTCH-1:0]               TEMP_FAULT_SEL,
    input  wire amtc_pkg::amtc_coef_t [amtc_pkg::NTCH-1:0]       TEMP_COEF,
    output logic [amtc_pkg::NTCH-1:0][amtc_pkg::THI_W-1:0] TEMP_HI,
    output logic [amtc_pkg::NTCH-1:0][amtc_pkg::TLO_W-1:0] TEMP_LO
);

    typedef enum logic {S_IDLE, S_CONV} amtc_st_t;

    amtc_st_t                         st_q;
    amtc_pkg::amtc_own_t              own_q;
    amtc_pkg::amtc_req_t              host_q;
    amtc_pkg::amtc_req_t              trim_q;
    logic                             host_pend_q;
    logic                             trim_pend_q;
    logic [amtc_pkg::NCUR-1:0]        sch_pend_q;
    logic [amtc_pkg::SCH_W-1:0]       sch_cnt_q;
    logic                             sch_tick;
    logic                             grant;
    logic                             conv_end;
    amtc_pkg::amtc_own_t              own_d;
    amtc_pkg::amtc_req_t              req_d;
    logic [amtc_pkg::RES_W-1:0]       scaled;
    logic [amtc_pkg::RES_W-1:0]       conv_res_q;
    logic [amtc_pkg::RES_W-1:0]       host_res_q;

    // ------------------------------------------------------------
    // Request capture and periodic scheduler
    // ------------------------------------------------------------
    assign sch_tick = (SCHED_PERIOD != amtc_pkg::SCH_RST) && (sch_cnt_q == SCHED_PERIOD);
    assign grant    = (st_q == S_IDLE) && (host_pend_q || trim_pend_q || (|sch_pend_q));
    assign conv_end = (st_q == S_CONV) && ADC_DONE;

    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
            sch_cnt_q <= amtc_pkg::SCH_RST;
        else if (sch_tick || SCHED_PERIOD == amtc_pkg::SCH_RST)
            sch_cnt_q <= amtc_pkg::SCH_RST;
        else
            sch_cnt_q <= sch_cnt_q + 16'h0001;
    end

    // New request wins over the grant that clears it
    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            host_pend_q <= 1'b0;
            trim_pend_q <= 1'b0;
            sch_pend_q  <= '0;
            host_q      <= '0;
            trim_q      <= '0;
        end
        else
        begin
            if (HOST_REQ)
                host_q <= HOST_SEL;
            if (TRIM_REQ)
                trim_q <= TRIM_SEL;
            host_pend_q <= HOST_REQ || (host_pend_q && !(grant && own_d == amtc_pkg::OWN_HOST));
            trim_pend_q <= TRIM_REQ || (trim_pend_q && !(grant && own_d == amtc_pkg::OWN_TRIM));
            sch_pend_q[0] <= sch_tick || (sch_pend_q[0] && !(grant && own_d == amtc_pkg::OWN_SCH0));
            sch_pend_q[1] <= sch_tick || (sch_pend_q[1] && !(grant && own_d == amtc_pkg::OWN_SCH1));
        end
    end

    // ------------------------------------------------------------
    // Arbitration: host, then trim, then scheduled currents
    // ------------------------------------------------------------
    always_comb
    begin
        own_d = amtc_pkg::OWN_SCH1;
        req_d = '{src: amtc_pkg::SRC_CUR1, hi_range: 1'b0};
        if (host_pend_q)
        begin
            own_d = amtc_pkg::OWN_HOST;
            req_d = host_q;
        end
        else if (trim_pend_q)
        begin
            own_d = amtc_pkg::OWN_TRIM;
            req_d = trim_q;
        end
        else if (sch_pend_q[0])
        begin
            own_d = amtc_pkg::OWN_SCH0;
            req_d = '{src: amtc_pkg::SRC_HVCUR, hi_range: 1'b0};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            st_q      <= S_IDLE;
            own_q     <= amtc_pkg::OWN_HOST;
            ADC_SEL   <= amtc_pkg::SRC_HVCUR;
            ADC_DIV   <= amtc_pkg::DIV1;
            ADC_START <= 1'b0;
        end
        else
        begin
            ADC_START <= grant;
            case (st_q)
                S_IDLE:
                    if (grant)
                    begin
                        st_q    <= S_CONV;
                        own_q   <= own_d;
                        ADC_SEL <= req_d.src;
                        case (req_d.src)
                            amtc_pkg::SRC_VOLT:
                                ADC_DIV <= req_d.hi_range ? amtc_pkg::DIV3 : amtc_pkg::DIV1;
                            amtc_pkg::SRC_HVOLT:
                                ADC_DIV <= req_d.hi_range ? amtc_pkg::DIV8 : amtc_pkg::DIV4;
                            default:
                                ADC_DIV <= amtc_pkg::DIV1;
                        endcase
                    end
                S_CONV:
                    if (ADC_DONE)
                        st_q <= S_IDLE;
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Digital multiplier and result latches
    // ------------------------------------------------------------
    always_comb
    begin
        scaled = {3'h0, ADC_DATA};
        case (ADC_DIV)
            amtc_pkg::DIV3: scaled = {2'h0, ADC_DATA, 1'b0} + {3'h0, ADC_DATA};
            amtc_pkg::DIV4: scaled = {1'b0, ADC_DATA, 2'h0};
            amtc_pkg::DIV8: scaled = {ADC_DATA, 3'h0};
            default:        scaled = {3'h0, ADC_DATA};
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            conv_res_q  <= amtc_pkg::RES_RST;
            host_res_q  <= amtc_pkg::RES_RST;
            TRIM_RESULT <= amtc_pkg::RES_RST;
            TRIM_DONE   <= 1'b0;
            HOST_DONE   <= 1'b0;
        end
        else
        begin
            TRIM_DONE <= conv_end && own_q == amtc_pkg::OWN_TRIM;
            if (conv_end)
                conv_res_q <= scaled;
            if (conv_end && own_q == amtc_pkg::OWN_HOST)
                host_res_q <= scaled;
            if (conv_end && own_q == amtc_pkg::OWN_TRIM)
                TRIM_RESULT <= scaled;
            if (conv_end && own_q == amtc_pkg::OWN_HOST)
                HOST_DONE <= 1'b1;
            else if (HOST_REQ)
                HOST_DONE <= 1'b0;
        end
    end

    assign RESULT_HI = host_res_q[amtc_pkg::RES_W-1 -: amtc_pkg::HI_W];
    assign RESULT_LO = host_res_q[amtc_pkg::LO_W-1:0];

    // ------------------------------------------------------------
    // Current averaging: acc holds eight times the average
    // ------------------------------------------------------------
    for (genvar i = 0; i < amtc_pkg::NCUR; i++)
    begin : g_cur
        logic [amtc_pkg::RES_W+amtc_pkg::AVG_FRAC-1:0] acc_q;
        amtc_pkg::amtc_own_t                            me;
        assign me = (i == 0) ? amtc_pkg::OWN_SCH0 : amtc_pkg::OWN_SCH1;
        always_ff @(posedge SYS_CLK or negedge RSTN)
        begin
            if (!RSTN)
                acc_q <= '0;
            else if (conv_end && own_q == me)
                acc_q <= acc_q - (acc_q >> amtc_pkg::AVG_FRAC) + {3'h0, scaled};
        end
        assign CUR_AVG[i] = acc_q[amtc_pkg::RES_W+amtc_pkg::AVG_FRAC-1:amtc_pkg::AVG_FRAC];
    end

    // ------------------------------------------------------------
    // Temperature conversion and exponential filter
    // ------------------------------------------------------------
    logic [23:0]                     t_prod;
    logic signed [15:0]              t_c;
    logic signed [amtc_pkg::TMP_W-1:0] t_val;

    always_comb
    begin
        t_prod = TEMP_IN.raw * TEMP_GAIN[TEMP_IN.ch];
        t_c    = $signed({2'h0, t_prod[23:amtc_pkg::GAIN_FRAC]})
               - $signed({2'h0, amtc_pkg::KELVIN_Q})
               + 16'(signed'(TEMP_OFS[TEMP_IN.ch]));
        if (t_c > $signed(16'h03FF))
            t_val = amtc_pkg::FAULT_POS;
        else if (t_c < $signed(16'hFC01))
            t_val = amtc_pkg::FAULT_NEG;
        else
            t_val = t_c[amtc_pkg::TMP_W-1:0];
        if (TEMP_IN.short_det)
            t_val = TEMP_FAULT_SEL[TEMP_IN.ch] ? amtc_pkg::FAULT_POS : amtc_pkg::FAULT_NEG;
        else if (TEMP_IN.open_det)
            t_val = TEMP_FAULT_SEL[TEMP_IN.ch] ? amtc_pkg::FAULT_NEG : amtc_pkg::FAULT_POS;
    end

    for (genvar c = 0; c < amtc_pkg::NTCH; c++)
    begin : g_tmp
        logic signed [amtc_pkg::TMP_W-1:0] avg_q;
        logic signed [amtc_pkg::TMP_W:0]   diff;
        assign diff = {t_val[amtc_pkg::TMP_W-1], t_val} - {avg_q[amtc_pkg::TMP_W-1], avg_q};
        always_ff @(posedge SYS_CLK or negedge RSTN)
        begin
            if (!RSTN)
                avg_q <= amtc_pkg::TMP_RST;
            else if (TEMP_VALID && TEMP_IN.ch == 2'(c))
                case (TEMP_COEF[c])
                    amtc_pkg::COEF8:
                        avg_q <= avg_q + 11'(diff >>> amtc_pkg::COEF8_SH);
                    amtc_pkg::COEF16:
                        avg_q <= avg_q + 11'(diff >>> amtc_pkg::COEF16_SH);
                    default:
                        avg_q <= t_val;
                endcase
        end
        assign TEMP_HI[c] = avg_q[amtc_pkg::TMP_W-1 -: amtc_pkg::THI_W];
        assign TEMP_LO[c] = avg_q[amtc_pkg::TLO_W-1:0];
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_host_grant;
        st_q == S_IDLE && host_pend_q;
    endsequence
    sequence s_host_end;
        conv_end && own_q == amtc_pkg::OWN_HOST;
    endsequence

    a_volt_div: assert property (ADC_START && ADC_SEL == amtc_pkg::SRC_VOLT
        |-> ADC_DIV inside {amtc_pkg::DIV1, amtc_pkg::DIV3})
        else $error("voltage monitor divider illegal");
    a_highv_div: assert property (ADC_START && ADC_SEL == amtc_pkg::SRC_HVOLT
        |-> ADC_DIV inside {amtc_pkg::DIV4, amtc_pkg::DIV8})
        else $error("high-voltage monitor not attenuated");
    a_scale_eight: assert property (conv_end && ADC_DIV == amtc_pkg::DIV8
        |=> conv_res_q == {$past(ADC_DATA), 3'h0})
        else $error("divide-by-eight result not scaled");
    a_cur_raw: assert property (conv_end
        && ADC_SEL inside {amtc_pkg::SRC_HVCUR, amtc_pkg::SRC_CUR1}
        |=> conv_res_q == {3'h0, $past(ADC_DATA)})
        else $error("current result multiplied");
    a_host_first: assert property (s_host_grant
        |=> ADC_START && own_q == amtc_pkg::OWN_HOST)
        else $error("host request not served first");
    a_single_conv: assert property (ADC_START |-> st_q == S_CONV && !$past(ADC_START))
        else $error("overlapping conversions");
    a_host_status: assert property (s_host_end ##1 1'b1
        |-> HOST_DONE && {RESULT_HI, RESULT_LO} == conv_res_q)
        else $error("host status or readout missing");
    a_sched_pend: assert property (sch_tick |=> &sch_pend_q)
        else $error("scheduled conversions not queued");
    a_fault_short: assert property (TEMP_VALID && TEMP_IN.short_det
        && !TEMP_FAULT_SEL[TEMP_IN.ch] |-> t_val == amtc_pkg::FAULT_NEG)
        else $error("short fault reading wrong");
    a_coef_one: assert property (TEMP_VALID && TEMP_IN.ch == 2'h0
        && TEMP_COEF[0] == amtc_pkg::COEF1 |=> g_tmp[0].avg_q == $past(t_val))
        else $error("unfiltered temperature not stored");

endmodule // amtc_top

// File: amtc_adc_model.sv
// Behavioural measurement ADC that answers conversion starts from the control block.
// Assumes start is a one-cycle pulse on clk; answer delay is set per conversion by lat (>= 1).
`timescale 1ns/1ns
module amtc_adc_model
(
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic                       start,
    input  wire amtc_pkg::amtc_src_t        sel,
    input  wire logic [3:0]                 lat,
    output logic                            done,
    output logic [amtc_pkg::RAW_W-1:0]      data
);
    // ------------------------------------------------------------
    // Conversion answer
    // ------------------------------------------------------------
    initial
    begin
        done = 1'b0;
        data = 10'h000;
        forever
        begin
            @(posedge clk);
            if (rstn === 1'b1 && start === 1'b1)
            begin
                repeat (lat) @(posedge clk);
                #1;
                done = 1'b1;
                data = 10'h2A5 + 10'h011 * {8'h00, sel};
                @(posedge clk);
                #1;
                done = 1'b0;
                // Released data shows the inverse so stale values never pass
                data = ~data;
            end
        end
    end
endmodule // amtc_adc_model

// File: tb.sv
// Self-checking bench for the measurement control and temperature conversion block.
// Assumes the ADC model in amtc_adc_model.sv answers every ADC_START.
`timescale 1ns/1ns
module tb;
    logic                       SYS_CLK = 1'b0;
    logic                       RSTN = 1'b0;
    logic                       HOST_REQ = 1'b0;
    amtc_pkg::amtc_req_t        HOST_SEL = '0;
    logic                       HOST_DONE;
    logic [7:0]                 RESULT_HI;
    logic [4:0]                 RESULT_LO;
    logic                       TRIM_REQ = 1'b0;
    amtc_pkg::amtc_req_t        TRIM_SEL = '0;
    logic                       TRIM_DONE;
    logic [12:0]                TRIM_RESULT;
    logic [15:0]                SCHED_PERIOD = 16'h0000;
    logic [1:0][12:0]           CUR_AVG;
    amtc_pkg::amtc_src_t        ADC_SEL;
    amtc_pkg::amtc_div_t        ADC_DIV;
    logic                       ADC_START;
    logic                       ADC_DONE;
    logic [9:0]                 ADC_DATA;
    logic                       TEMP_VALID = 1'b0;
    amtc_pkg::amtc_tsamp_t      TEMP_IN = '0;
    logic [2:0][10:0]           TEMP_GAIN = {11'h400, 11'h200, 11'h400};
    logic [2:0][8:0]            TEMP_OFS = {9'h000, 9'h000, 9'h1FC};
    logic [2:0]                 TEMP_FAULT_SEL = 3'b010;
    amtc_pkg::amtc_coef_t [2:0] TEMP_COEF = '{amtc_pkg::COEF8, amtc_pkg::COEF1, amtc_pkg::COEF1};
    logic [2:0][7:0]            TEMP_HI;
    logic [2:0][2:0]            TEMP_LO;
    amtc_pkg::amtc_src_t        src;
    logic [3:0]                 lat = 4'h1;
    int                         failures = 0;
    int                         total_checks = 0;
    int                         trim_cnt = 0;
    logic [12:0]                trim_res;
    logic                       host_before;

    always #5 SYS_CLK = ~SYS_CLK;

    amtc_top i_amtc_top (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .HOST_REQ(HOST_REQ),
        .HOST_SEL(HOST_SEL), .HOST_DONE(HOST_DONE), .RESULT_HI(RESULT_HI),
        .RESULT_LO(RESULT_LO), .TRIM_REQ(TRIM_REQ), .TRIM_SEL(TRIM_SEL),
        .TRIM_DONE(TRIM_DONE), .TRIM_RESULT(TRIM_RESULT), .SCHED_PERIOD(SCHED_PERIOD),
        .CUR_AVG(CUR_AVG), .ADC_SEL(ADC_SEL), .ADC_DIV(ADC_DIV), .ADC_START(ADC_START),
        .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA), .TEMP_VALID(TEMP_VALID),
        .TEMP_IN(TEMP_IN), .TEMP_GAIN(TEMP_GAIN), .TEMP_OFS(TEMP_OFS),
        .TEMP_FAULT_SEL(TEMP_FAULT_SEL), .TEMP_COEF(TEMP_COEF), .TEMP_HI(TEMP_HI),
        .TEMP_LO(TEMP_LO));

    amtc_adc_model i_amtc_adc_model (.clk(SYS_CLK), .rstn(RSTN), .start(ADC_START),
        .sel(ADC_SEL), .lat(lat), .done(ADC_DONE), .data(ADC_DATA));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [12:0] expv(input amtc_pkg::amtc_src_t s, input logic h);
        logic [12:0] r;
        r = {3'h0, 10'h2A5 + 10'h011 * {8'h00, s}};
        case (s)
            amtc_pkg::SRC_VOLT:  return h ? r * 13'h0003 : r;
            amtc_pkg::SRC_HVOLT: return h ? r * 13'h0008 : r * 13'h0004;
            default:             return r;
        endcase
    endfunction

    task automatic host_conv(input amtc_pkg::amtc_src_t s, input logic h, input logic trim);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        #1;
        HOST_REQ = 1'b1;
        HOST_SEL = '{src: s, hi_range: h};
        TRIM_REQ = trim;
        TRIM_SEL = '{src: amtc_pkg::SRC_VOLT, hi_range: 1'b1};
        @(posedge SYS_CLK);
        #1;
        HOST_REQ = 1'b0;
        TRIM_REQ = 1'b0;
        check({15'h0, HOST_DONE}, 16'h0000);
        while (HOST_DONE !== 1'b1 && n < 100)
        begin
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        if (n == 100)
        begin
            failures++;
            tally_and_finish();
        end
    endtask

    task automatic temp(input logic [1:0] ch, input logic sh, input logic op, input logic [12:0] r);
        @(posedge SYS_CLK);
        #1;
        TEMP_VALID = 1'b1;
        TEMP_IN = '{ch: ch, short_det: sh, open_det: op, raw: r};
        @(posedge SYS_CLK);
        #1;
        TEMP_VALID = 1'b0;
        @(posedge SYS_CLK);
        #1;
    endtask

    function automatic logic [15:0] tv(input int ch);
        return {5'h00, TEMP_HI[ch], TEMP_LO[ch]};
    endfunction

    always @(posedge SYS_CLK)
    begin
        if (TRIM_DONE === 1'b1)
        begin
            trim_cnt++;
            trim_res = TRIM_RESULT;
            host_before = HOST_DONE;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge SYS_CLK);
        check({15'h0, HOST_DONE}, 16'h0000);
        check({14'h0, ADC_DIV}, {14'h0, amtc_pkg::DIV1});
        #1;
        RSTN = 1'b1;
        // Every source with both ranges, fast and slow converter
        for (int i = 0; i < 8; i++)
        begin
            lat = i[0] ? 4'h6 : 4'h1;
            src = amtc_pkg::amtc_src_t'(i[2:1]);
            host_conv(src, i[0], 1'b0);
            check({14'h0, ADC_SEL}, {14'h0, src});
            case (i)
                4:       check({14'h0, ADC_DIV}, {14'h0, amtc_pkg::DIV4});
                5:       check({14'h0, ADC_DIV}, {14'h0, amtc_pkg::DIV8});
                7:       check({14'h0, ADC_DIV}, {14'h0, amtc_pkg::DIV3});
                default: check({14'h0, ADC_DIV}, {14'h0, amtc_pkg::DIV1});
            endcase
            check({3'h0, RESULT_HI, RESULT_LO}, {3'h0, expv(src, i[0])});
        end
        // Host and trim in the same cycle: both served, host first
        host_conv(amtc_pkg::SRC_HVOLT, 1'b1, 1'b1);
        for (int n = 0; n < 100 && trim_cnt == 0; n++)
            @(posedge SYS_CLK);
        check(trim_cnt[15:0], 16'h0001);
        check({15'h0, host_before}, 16'h0001);
        check({3'h0, trim_res}, {3'h0, expv(amtc_pkg::SRC_VOLT, 1'b1)});
        check({3'h0, RESULT_HI, RESULT_LO}, {3'h0, expv(amtc_pkg::SRC_HVOLT, 1'b1)});
        // Temperature conversion
        temp(2'h0, 1'b0, 1'b0, 13'h04A9);
        check(tv(0), 16'h0060);
        temp(2'h3, 1'b1, 1'b0, 13'h0000);
        check(tv(0), 16'h0060);
        temp(2'h1, 1'b0, 1'b0, 13'h08DA);
        check(tv(1), 16'h0028);
        temp(2'h0, 1'b0, 1'b0, 13'h1FFF);
        check(tv(0), 16'h03FF);
        temp(2'h0, 1'b0, 1'b0, 13'h0000);
        check(tv(0), 16'h0401);
        temp(2'h0, 1'b1, 1'b0, 13'h04A9);
        check(tv(0), 16'h0401);
        temp(2'h0, 1'b0, 1'b1, 13'h04A9);
        check(tv(0), 16'h03FF);
        temp(2'h1, 1'b1, 1'b0, 13'h04A9);
        check(tv(1), 16'h03FF);
        temp(2'h1, 1'b0, 1'b1, 13'h04A9);
        check(tv(1), 16'h0401);
        temp(2'h2, 1'b0, 1'b0, 13'h04A9);
        check(tv(2), 16'h000C);
        temp(2'h2, 1'b0, 1'b0, 13'h04A9);
        check(tv(2), 16'h0017);
        // Coefficient 16 on the same channel: 23 + (100 - 23) / 16
        TEMP_COEF[2] = amtc_pkg::COEF16;
        temp(2'h2, 1'b0, 1'b0, 13'h04A9);
        check(tv(2), 16'h001B);
        // Periodic current averaging settles on the constant sample
        SCHED_PERIOD = 16'h0013;
        repeat (3000) @(posedge SYS_CLK);
        #1;
        check({3'h0, CUR_AVG[0]}, {3'h0, expv(amtc_pkg::SRC_HVCUR, 1'b0)});
        check({3'h0, CUR_AVG[1]}, {3'h0, expv(amtc_pkg::SRC_CUR1, 1'b0)});
        host_conv(amtc_pkg::SRC_VOLT, 1'b0, 1'b0);
        check({3'h0, RESULT_HI, RESULT_LO}, {3'h0, expv(amtc_pkg::SRC_VOLT, 1'b0)});
        tally_and_finish();
    end
endmodule // tb
